/* File: design/crf_pkg.sv */
// package: constants, register map and state type for the cpu register file
package crf_pkg;
   localparam int          ADDR_W      = 8;
   localparam int          PS_W        = 11;
   // -------------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0]  OFF_ACC_A   = 8'h00;
   localparam logic [7:0]  OFF_ACC_B   = 8'h04;
   localparam logic [7:0]  OFF_IDX_X   = 8'h08;
   localparam logic [7:0]  OFF_IDX_Y   = 8'h0C;
   localparam logic [7:0]  OFF_SP      = 8'h10;
   localparam logic [7:0]  OFF_PC      = 8'h14;
   localparam logic [7:0]  OFF_PG      = 8'h18;
   localparam logic [7:0]  OFF_DT      = 8'h1C;
   localparam logic [7:0]  OFF_DPR     = 8'h20;
   localparam logic [7:0]  OFF_PS      = 8'h24;
   localparam logic [7:0]  OFF_CMD     = 8'h28;
   localparam logic [7:0]  OFF_OPND    = 8'h2C;
   localparam logic [7:0]  OFF_EA      = 8'h30;
   localparam logic [7:0]  OFF_DST     = 8'h34;
   localparam logic [7:0]  OFF_STAT    = 8'h38;
   // -------------------------------------------------------------------
   // fields, reset values, commands
   // -------------------------------------------------------------------
   localparam int          BIT_M       = 5;
   localparam int          BIT_X       = 4;
   localparam logic [10:0] PS_RST      = 11'h004;
   localparam logic [3:0]  OP_NOP      = 4'h0;
   localparam logic [3:0]  OP_PC_INC   = 4'h1;
   localparam logic [3:0]  OP_PC_ADD   = 4'h2;
   localparam logic [3:0]  OP_INT      = 4'h3;
   localparam logic [3:0]  OP_CALL_L   = 4'h4;
   localparam logic [3:0]  OP_CALL_S   = 4'h5;
   localparam logic [3:0]  OP_RET_INT  = 4'h6;
   localparam logic [3:0]  OP_RET_L    = 4'h7;
   localparam logic [3:0]  OP_RET_S    = 4'h8;
   localparam logic [3:0]  OP_EA_IDX   = 4'h9;
   localparam logic [3:0]  OP_EA_DP    = 4'hA;
   localparam logic [3:0]  OP_EA_BLK   = 4'hB;
   localparam logic [2:0]  SLOT_PG     = 3'h0;
   localparam logic [2:0]  SLOT_PCH    = 3'h1;
   localparam logic [2:0]  SLOT_PCL    = 3'h2;
   localparam logic [2:0]  SLOT_PSH    = 3'h3;
   localparam logic [2:0]  SLOT_PSL    = 3'h4;
   localparam logic [15:0] INT_FRAME   = 16'h0005;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP_REQ, ST_POP_TAKE} crf_state_t;
endpackage : crf_pkg

/* File: design/crf_regfile.sv */
// module: cpu register file with stack sequencer, address generation and axi4-lite slave
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module crf_regfile (
   input  wire logic        aclk,       // clock, 100 MHz
   input  wire logic        aresetn,    // synchronous reset, active low
   input  wire logic [7:0]  awaddr,     // write address
   input  wire logic [2:0]  awprot,     // write protection, unused
   input  wire logic        awvalid,    // write address valid
   output logic             awready,    // write address ready
   input  wire logic [31:0] wdata,      // write data
   input  wire logic [3:0]  wstrb,      // write byte strobes
   input  wire logic        wvalid,     // write data valid
   output logic             wready,     // write data ready
   output logic [1:0]       bresp,      // write response
   output logic             bvalid,     // write response valid
   input  wire logic        bready,     // write response ready
   input  wire logic [7:0]  araddr,     // read address
   input  wire logic [2:0]  arprot,     // read protection, unused
   input  wire logic        arvalid,    // read address valid
   output logic             arready,    // read address ready
   output logic [31:0]      rdata,      // read data
   output logic [1:0]       rresp,      // read response
   output logic             rvalid,     // read data valid
   input  wire logic        rready,     // read data ready
   output logic             stk_we,     // stack byte write strobe
   output logic             stk_re,     // stack byte read strobe
   output logic [15:0]      stk_addr,   // stack byte address, bank 0
   output logic [7:0]       stk_wdata,  // stack write byte
   input  wire logic [7:0]  stk_rdata   // stack read byte, valid cycle after stk_re
);
   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      crf_pkg::crf_state_t st;
      logic [15:0]         acc_a;
      logic [15:0]         acc_b;
      logic [15:0]         idx_x;
      logic [15:0]         idx_y;
      logic [15:0]         sp;
      logic [15:0]         pc;
      logic [15:0]         direct_page_base;
      logic [7:0]          pg;
      logic [7:0]          dt;
      logic [10:0]         ps;
      logic [31:0]         opnd;
      logic [23:0]         ea;
      logic [23:0]         dst;
      logic                dp_slow;
      logic [2:0]          idx;
      logic [2:0]          first;
      logic [2:0]          last;
      logic                pop_wait;
      logic                aw_have;
      logic                w_have;
      logic [7:0]          awaddr;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic                stk_we;
      logic                stk_re;
      logic [15:0]         stk_addr;
      logic [7:0]          stk_wdata;
   } crf_regs_t;

   crf_regs_t q;
   crf_regs_t d;
   logic      wr_fire;
   logic      cmd_go;
   logic [3:0] cmd_op;
   logic [31:0] wmerge;

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic crf_mapped(input logic [7:0] a);
      crf_mapped = (a[1:0] == 2'h0) && (a <= crf_pkg::OFF_STAT);
   endfunction : crf_mapped

   function automatic logic [31:0] crf_lanes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         crf_lanes[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction : crf_lanes

   // 8-bit width keeps the upper byte
   function automatic logic [15:0] crf_width(input logic [15:0] old, input logic [15:0] nw,
                                             input logic narrow);
      crf_width = narrow ? {old[15:8], nw[7:0]} : nw;
   endfunction : crf_width

   function automatic logic [7:0] crf_push_byte(input logic [2:0] slot, input logic [7:0] pg,
                                                input logic [15:0] pc, input logic [10:0] ps);
      unique case (slot)
         crf_pkg::SLOT_PG:  crf_push_byte = pg;
         crf_pkg::SLOT_PCH: crf_push_byte = pc[15:8];
         crf_pkg::SLOT_PCL: crf_push_byte = pc[7:0];
         crf_pkg::SLOT_PSH: crf_push_byte = {5'h00, ps[10:8]};
         default:           crf_push_byte = ps[7:0];
      endcase
   endfunction : crf_push_byte

   assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
   assign cmd_go  = wr_fire && (q.awaddr == crf_pkg::OFF_CMD);
   assign cmd_op  = q.wdata[3:0];
   assign wmerge  = q.wdata;

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      logic [31:0] nv;
      logic [15:0] xeff;
      nv = 32'h0000_0000;
      xeff = q.ps[crf_pkg::BIT_X] ? {8'h00, q.idx_x[7:0]} : q.idx_x;
      d = q;
      d.stk_we = 1'b0;
      d.stk_re = 1'b0;
      if (q.awready && awvalid) begin
         d.aw_have = 1'b1;
         d.awaddr  = awaddr;
      end
      if (q.wready && wvalid) begin
         d.w_have = 1'b1;
         d.wdata  = wdata;
         d.wstrb  = wstrb;
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = crf_mapped(q.awaddr) ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
         unique case (q.awaddr)
            crf_pkg::OFF_ACC_A: begin
               nv = crf_lanes({16'h0000, q.acc_a}, wmerge, q.wstrb);
               d.acc_a = crf_width(q.acc_a, nv[15:0], q.ps[crf_pkg::BIT_M]);
            end
            crf_pkg::OFF_ACC_B: begin
               nv = crf_lanes({16'h0000, q.acc_b}, wmerge, q.wstrb);
               d.acc_b = crf_width(q.acc_b, nv[15:0], q.ps[crf_pkg::BIT_M]);
            end
            crf_pkg::OFF_IDX_X: begin
               nv = crf_lanes({16'h0000, q.idx_x}, wmerge, q.wstrb);
               d.idx_x = crf_width(q.idx_x, nv[15:0], q.ps[crf_pkg::BIT_X]);
            end
            crf_pkg::OFF_IDX_Y: begin
               nv = crf_lanes({16'h0000, q.idx_y}, wmerge, q.wstrb);
               d.idx_y = crf_width(q.idx_y, nv[15:0], q.ps[crf_pkg::BIT_X]);
            end
            crf_pkg::OFF_SP: begin
               nv = crf_lanes({16'h0000, q.sp}, wmerge, q.wstrb);
               d.sp = nv[15:0];
            end
            crf_pkg::OFF_PC: begin
               nv = crf_lanes({16'h0000, q.pc}, wmerge, q.wstrb);
               d.pc = nv[15:0];
            end
            crf_pkg::OFF_PG: begin
               nv = crf_lanes({24'h000000, q.pg}, wmerge, q.wstrb);
               d.pg = nv[7:0];
            end
            crf_pkg::OFF_DT: begin
               nv = crf_lanes({24'h000000, q.dt}, wmerge, q.wstrb);
               d.dt = nv[7:0];
            end
            crf_pkg::OFF_DPR: begin
               nv = crf_lanes({16'h0000, q.direct_page_base}, wmerge, q.wstrb);
               d.direct_page_base = nv[15:0];
            end
            crf_pkg::OFF_PS: begin
               nv = crf_lanes({21'h000000, q.ps}, wmerge, q.wstrb);
               d.ps = nv[10:0];
            end
            crf_pkg::OFF_OPND: begin
               d.opnd = crf_lanes(q.opnd, wmerge, q.wstrb);
            end
            crf_pkg::OFF_CMD: begin
               unique case (cmd_op)
                  crf_pkg::OP_PC_INC: begin
                     {d.pg, d.pc} = {q.pg, q.pc} + 24'h000001;
                  end
                  crf_pkg::OP_PC_ADD: begin
                     {d.pg, d.pc} = {q.pg, q.pc} + {{8{q.opnd[15]}}, q.opnd[15:0]};
                  end
                  crf_pkg::OP_INT: begin
                     d.st    = crf_pkg::ST_PUSH;
                     d.first = crf_pkg::SLOT_PG;
                     d.last  = crf_pkg::SLOT_PSL;
                     d.idx   = crf_pkg::SLOT_PG;
                  end
                  crf_pkg::OP_CALL_L, crf_pkg::OP_CALL_S: begin
                     d.st    = crf_pkg::ST_PUSH;
                     d.first = (cmd_op == crf_pkg::OP_CALL_L) ? crf_pkg::SLOT_PG : crf_pkg::SLOT_PCH;
                     d.last  = crf_pkg::SLOT_PCL;
                     d.idx   = d.first;
                  end
                  crf_pkg::OP_RET_INT, crf_pkg::OP_RET_L, crf_pkg::OP_RET_S: begin
                     d.st    = crf_pkg::ST_POP_REQ;
                     d.first = (cmd_op == crf_pkg::OP_RET_S) ? crf_pkg::SLOT_PCH : crf_pkg::SLOT_PG;
                     d.last  = (cmd_op == crf_pkg::OP_RET_INT) ? crf_pkg::SLOT_PSL : crf_pkg::SLOT_PCL;
                     d.idx   = d.last;
                  end
                  crf_pkg::OP_EA_IDX: begin
                     d.ea = {q.dt, q.opnd[15:0]} + {8'h00, xeff};
                  end
                  crf_pkg::OP_EA_DP: begin
                     d.ea      = {8'h00, q.direct_page_base} + {16'h0000, q.opnd[7:0]};
                     d.dp_slow = (q.direct_page_base[7:0] != 8'h00);
                  end
                  crf_pkg::OP_EA_BLK: begin
                     d.ea  = {q.opnd[31:24], q.idx_x};
                     d.dst = {q.opnd[23:16], q.idx_y};
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
      // -------------------------------------------------------------------
      // stack sequencer
      // -------------------------------------------------------------------
      unique case (q.st)
         crf_pkg::ST_IDLE: begin
         end
         crf_pkg::ST_PUSH: begin
            d.stk_we    = 1'b1;
            d.stk_addr  = q.sp;
            d.stk_wdata = crf_push_byte(q.idx, q.pg, q.pc, q.ps);
            d.sp        = q.sp - 16'h0001;
            d.idx       = q.idx + 3'h1;
            if (q.idx == q.last) begin
               d.st = crf_pkg::ST_IDLE;
            end
         end
         crf_pkg::ST_POP_REQ: begin
            d.stk_re   = 1'b1;
            d.stk_addr = q.sp + 16'h0001;
            d.sp       = q.sp + 16'h0001;
            d.st       = crf_pkg::ST_POP_TAKE;
            d.pop_wait = 1'b1;
         end
         crf_pkg::ST_POP_TAKE: begin
            // the byte arrives the cycle after the registered read strobe, so wait one cycle
            if (q.pop_wait) begin
               d.pop_wait = 1'b0;
            end else begin
               unique case (q.idx)
                  crf_pkg::SLOT_PG:  d.pg       = stk_rdata;
                  crf_pkg::SLOT_PCH: d.pc[15:8] = stk_rdata;
                  crf_pkg::SLOT_PCL: d.pc[7:0]  = stk_rdata;
                  crf_pkg::SLOT_PSH: d.ps[10:8] = stk_rdata[2:0];
                  default:           d.ps[7:0]  = stk_rdata;
               endcase
               d.idx = q.idx - 3'h1;
               d.st  = (q.idx == q.first) ? crf_pkg::ST_IDLE : crf_pkg::ST_POP_REQ;
            end
         end
      endcase
      // -------------------------------------------------------------------
      // read channel
      // -------------------------------------------------------------------
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (q.arready && arvalid) begin
         d.rvalid = 1'b1;
         d.rresp  = crf_mapped(araddr) ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
         unique case (araddr)
            crf_pkg::OFF_ACC_A: d.rdata = {16'h0000, q.acc_a};
            crf_pkg::OFF_ACC_B: d.rdata = {16'h0000, q.acc_b};
            crf_pkg::OFF_IDX_X: d.rdata = {16'h0000, q.idx_x};
            crf_pkg::OFF_IDX_Y: d.rdata = {16'h0000, q.idx_y};
            crf_pkg::OFF_SP:    d.rdata = {16'h0000, q.sp};
            crf_pkg::OFF_PC:    d.rdata = {16'h0000, q.pc};
            crf_pkg::OFF_PG:    d.rdata = {24'h000000, q.pg};
            crf_pkg::OFF_DT:    d.rdata = {24'h000000, q.dt};
            crf_pkg::OFF_DPR:   d.rdata = {16'h0000, q.direct_page_base};
            crf_pkg::OFF_PS:    d.rdata = {21'h000000, q.ps};
            crf_pkg::OFF_OPND:  d.rdata = q.opnd;
            crf_pkg::OFF_EA:    d.rdata = {8'h00, q.ea};
            crf_pkg::OFF_DST:   d.rdata = {8'h00, q.dst};
            crf_pkg::OFF_STAT:  d.rdata = {30'h00000000, q.dp_slow, q.st != crf_pkg::ST_IDLE};
            default:            d.rdata = 32'h0000_0000;
         endcase
      end
      // writes wait while the sequencer owns the registers
      d.awready = !d.aw_have && !d.bvalid && (d.st == crf_pkg::ST_IDLE);
      d.wready  = !d.w_have && !d.bvalid;
      d.arready = !d.rvalid;
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q    <= '0;
         q.st <= crf_pkg::ST_IDLE;
         q.ps <= crf_pkg::PS_RST;
      end else begin
         q <= d;
      end
   end

   assign awready   = q.awready;
   assign wready    = q.wready;
   assign bvalid    = q.bvalid;
   assign bresp     = q.bresp;
   assign arready   = q.arready;
   assign rvalid    = q.rvalid;
   assign rdata     = q.rdata;
   assign rresp     = q.rresp;
   assign stk_we    = q.stk_we;
   assign stk_re    = q.stk_re;
   assign stk_addr  = q.stk_addr;
   assign stk_wdata = q.stk_wdata;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking crf_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_acc_narrow_keep: assert property (
      (cmd_go == 1'b0 && wr_fire && q.awaddr == crf_pkg::OFF_ACC_A && q.ps[crf_pkg::BIT_M])
      |=> (q.acc_a[15:8] == $past(q.acc_a[15:8])))
      else $error("accumulator upper byte changed in 8-bit mode");
   a_idx_narrow_keep: assert property (
      (wr_fire && q.awaddr == crf_pkg::OFF_IDX_X && q.ps[crf_pkg::BIT_X])
      |=> (q.idx_x[15:8] == $past(q.idx_x[15:8])))
      else $error("index upper byte changed in 8-bit mode");
   a_pc_carry_bank: assert property (
      (cmd_go && cmd_op == crf_pkg::OP_PC_INC)
      |=> ({q.pg, q.pc} == $past({q.pg, q.pc}) + 24'h000001))
      else $error("counter increment did not carry into bank");
   a_block_src_addr: assert property (
      (cmd_go && cmd_op == crf_pkg::OP_EA_BLK)
      |=> (q.ea == {$past(q.opnd[31:24]), $past(q.idx_x)}))
      else $error("block source address wrong");
   a_block_dst_addr: assert property (
      (cmd_go && cmd_op == crf_pkg::OP_EA_BLK)
      |=> (q.dst == {$past(q.opnd[23:16]), $past(q.idx_y)}))
      else $error("block destination address wrong");
   a_dp_window_addr: assert property (
      (cmd_go && cmd_op == crf_pkg::OP_EA_DP)
      |=> (q.ea == {8'h00, $past(q.direct_page_base)} + {16'h0000, $past(q.opnd[7:0])}))
      else $error("direct page address wrong");
   a_push_bank_first: assert property (
      (q.st == crf_pkg::ST_PUSH && q.idx == crf_pkg::SLOT_PG)
      |=> (stk_we && stk_wdata == $past(q.pg) && stk_addr == $past(q.sp)))
      else $error("program bank not pushed first at stack pointer");
   a_int_frame_five: assert property (
      (q.st == crf_pkg::ST_PUSH && $past(q.st) == crf_pkg::ST_IDLE && q.last == crf_pkg::SLOT_PSL
       && q.first == crf_pkg::SLOT_PG)
      |-> ##5 (q.st == crf_pkg::ST_IDLE && q.sp == $past(q.sp, 5) - crf_pkg::INT_FRAME))
      else $error("stack pointer not lowered by five after interrupt entry");
   a_pop_step_sp: assert property (
      (q.st == crf_pkg::ST_POP_REQ) |=> (stk_re && q.sp == $past(q.sp) + 16'h0001
       && q.st == crf_pkg::ST_POP_TAKE))
      else $error("pop step did not raise stack pointer");

   c_int_entry: cover property (cmd_go && cmd_op == crf_pkg::OP_INT);
   c_ret_int:   cover property (q.st == crf_pkg::ST_POP_TAKE && q.idx == crf_pkg::SLOT_PG);
   c_bank_wrap: cover property (cmd_go && cmd_op == crf_pkg::OP_PC_INC && q.pc == 16'hFFFF);
   c_dp_bank1:  cover property (cmd_go && cmd_op == crf_pkg::OP_EA_DP && q.direct_page_base >= 16'hFF01);

endmodule : crf_regfile
`default_nettype wire

/* File: dv/crf_stk_mem.sv */
// stack memory model standing at the register file's stack port
`timescale 1ns/1ps
`default_nettype none
module crf_stk_mem (
   input  wire logic        aclk,   // clock
   input  wire logic        we,     // byte write strobe
   input  wire logic        re,     // byte read strobe
   input  wire logic [15:0] addr,   // byte address
   input  wire logic [7:0]  wdata,  // write byte
   output logic [7:0]       rdata   // read byte, the cycle after re
);
   logic [7:0] mem [0:65535];
   always @(posedge aclk) begin
      if (we) mem[addr] <= wdata;
      // outside a read the byte keeps toggling so stale data never looks valid
      rdata <= re ? mem[addr] : ~rdata;
   end
endmodule : crf_stk_mem
`default_nettype wire

/* File: dv/cpu_register_file_addressing_tb.sv */
// self-checking bench for the cpu register file
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_addressing_tb;
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic        stk_we, stk_re;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, stk_wdata, stk_rdata;
   logic [15:0] stk_addr;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [1:0]  bresp, rresp, br;
   int          error_cnt = 0, num_checks = 0;
   always #5 aclk = ~aclk;
   crf_regfile crf_regfile_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
      .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));
   crf_stk_mem crf_stk_mem_i (.aclk(aclk), .we(stk_we), .re(stk_re), .addr(stk_addr),
      .wdata(stk_wdata), .rdata(stk_rdata));
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw, w;
      aw = 1; w = 1;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && awready) begin aw = 0; awvalid <= 1'b0; end
         if (w && wready) begin w = 0; wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      br = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata; br = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic op(input logic [3:0] c);
      wr(crf_pkg::OFF_CMD, {28'h0, c});
      do rd(crf_pkg::OFF_STAT); while (v[0] !== 1'b0);
   endtask : op
   task automatic t_width;
      logic [7:0]  o [4];
      logic [31:0] p [4];
      o = '{crf_pkg::OFF_ACC_A, crf_pkg::OFF_ACC_B, crf_pkg::OFF_IDX_X, crf_pkg::OFF_IDX_Y};
      p = '{32'h020, 32'h020, 32'h010, 32'h010};
      rd(crf_pkg::OFF_PS); chk("status", v, 32'h004);
      chk("rresp", {30'h0, br}, {30'h0, crf_pkg::RESP_OKAY});
      for (int i = 0; i < 4; i++) begin
         wr(crf_pkg::OFF_PS, 32'h0); wr(o[i], 32'hABCD); wr(crf_pkg::OFF_PS, p[i]); wr(o[i], 32'h5612);
         rd(o[i]); chk("narrow", v, 32'hAB12);
      end
      wr(crf_pkg::OFF_PS, 32'h004);
      chk("bresp", {30'h0, br}, {30'h0, crf_pkg::RESP_OKAY});
   endtask : t_width
   task automatic t_bank;
      wr(crf_pkg::OFF_PC, 32'hFFFF); wr(crf_pkg::OFF_PG, 32'h12); op(crf_pkg::OP_PC_INC);
      rd(crf_pkg::OFF_PC); chk("pc", v, 32'h0);
      rd(crf_pkg::OFF_PG); chk("pg", v, 32'h13);
      wr(crf_pkg::OFF_PC, 32'h1); wr(crf_pkg::OFF_OPND, 32'hFFFE); op(crf_pkg::OP_PC_ADD);
      rd(crf_pkg::OFF_PC); chk("pc", v, 32'hFFFF);
      rd(crf_pkg::OFF_PG); chk("pg", v, 32'h12);
   endtask : t_bank
   task automatic t_stack;
      logic [7:0] e [5];
      e = '{8'h12, 8'h34, 8'h56, 8'h00, 8'h04};
      wr(crf_pkg::OFF_SP, 32'h01FF); wr(crf_pkg::OFF_PC, 32'h3456);
      op(crf_pkg::OP_INT);
      rd(crf_pkg::OFF_SP); chk("sp", v, 32'h01FA);
      for (int i = 0; i < 5; i++) chk("frame", {24'h0, crf_stk_mem_i.mem[16'h01FF - i]}, {24'h0, e[i]});
      wr(crf_pkg::OFF_PC, 32'h0); wr(crf_pkg::OFF_PG, 32'h0); op(crf_pkg::OP_RET_INT);
      rd(crf_pkg::OFF_SP); chk("sp", v, 32'h01FF);
      rd(crf_pkg::OFF_PC); chk("pc", v, 32'h3456);
      rd(crf_pkg::OFF_PG); chk("pg", v, 32'h12);
      op(crf_pkg::OP_CALL_S); rd(crf_pkg::OFF_SP); chk("sp", v, 32'h01FD);
      op(crf_pkg::OP_RET_S); op(crf_pkg::OP_CALL_L); rd(crf_pkg::OFF_SP); chk("sp", v, 32'h01FC);
      op(crf_pkg::OP_RET_L); rd(crf_pkg::OFF_SP); chk("sp", v, 32'h01FF);
   endtask : t_stack
   task automatic t_addr;
      wr(crf_pkg::OFF_DT, 32'h05); wr(crf_pkg::OFF_IDX_X, 32'h0010); wr(crf_pkg::OFF_OPND, 32'h1000);
      op(crf_pkg::OP_EA_IDX); rd(crf_pkg::OFF_EA); chk("ea", v, 32'h051010);
      wr(crf_pkg::OFF_DPR, 32'hFF80); wr(crf_pkg::OFF_OPND, 32'hA0);
      op(crf_pkg::OP_EA_DP); rd(crf_pkg::OFF_EA); chk("ea", v, 32'h010020);
      rd(crf_pkg::OFF_STAT); chk("slow", v, 32'h2);
      wr(crf_pkg::OFF_IDX_X, 32'h1111); wr(crf_pkg::OFF_IDX_Y, 32'h2222); wr(crf_pkg::OFF_OPND, 32'h33440000);
      op(crf_pkg::OP_EA_BLK); rd(crf_pkg::OFF_EA); chk("src", v, 32'h331111);
      rd(crf_pkg::OFF_DST); chk("dst", v, 32'h442222);
      wr(crf_pkg::OFF_PG, 32'h0); wr(crf_pkg::OFF_DT, 32'h0);
      rd(crf_pkg::OFF_DT); chk("dt", v, 32'h0);
   endtask : t_addr
   task automatic t_unmap;
      wr(8'h3C, 32'h1); chk("bresp", {30'h0, br}, {30'h0, crf_pkg::RESP_SLVERR});
      rd(8'h3C); chk("rdata", v, 32'h0);
      chk("rresp", {30'h0, br}, {30'h0, crf_pkg::RESP_SLVERR});
   endtask : t_unmap
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_width; t_bank; t_stack; t_addr; t_unmap;
      final_report;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      final_report;
   end
endmodule : cpu_register_file_addressing_tb
`default_nettype wire
